// file: rtl/or_and_move_instruction_decode.v
// decode and execute of the or / pointer load / move / bank load instruction group
//
// Operation
// - or immediate into accumulator
// - or and file moves set n, z only
// - or file; destination bit picks target
// - access bit zero uses fixed access bank
// - extended mode, low address means indexed offset
// - pointer load: two words, 12-bit immediate
// - move file to accumulator or itself
// - memory move: 12-bit source, 12-bit destination
// - memory move: read first, write second cycle
// - accumulator may be memory move endpoint
// - bank load clears upper four bits
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "or_move_map.vh"
module or_and_move_instruction_decode #(
	parameter ACC_ADDR_P = `ACC_ADDR
) (
	// clock and reset
	input  wire        clk,
	input  wire        sys_rst,
	// instruction stream
	input  wire [15:0] instr_word,
	input  wire        instr_valid,
	input  wire        ext_mode,
	// data memory
	input  wire [7:0]  mem_rdata,
	input  wire [7:0]  index_base,
	output reg  [11:0] mem_addr,
	output reg         mem_rd,
	output reg         mem_wr,
	output reg  [7:0]  mem_wdata,
	// core state
	output reg  [7:0]  accumulator,
	output reg  [7:0]  bank_select_register,
	output reg  [11:0] pointer_0,
	output reg  [11:0] pointer_1,
	output reg  [11:0] pointer_2,
	output reg  [1:0]  flags_nz,
	output reg         instr_ready,
	output reg  [1:0]  quarter
);
	localparam S_Q1   = 6'h01;
	localparam S_Q2   = 6'h02;
	localparam S_Q3   = 6'h04;
	localparam S_Q4   = 6'h08;
	localparam S_MM2  = 6'h10;
	localparam S_PTR2 = 6'h20;

	localparam K_OR_IMM = 3'd1;
	localparam K_OR_F   = 3'd2;
	localparam K_MOV_F  = 3'd3;
	localparam K_BANK   = 3'd4;
	localparam K_PTR    = 3'd5;
	localparam K_MM     = 3'd6;
	localparam K_NONE   = 3'd0;
	localparam K_MM_DST = 3'd7;

	reg [5:0]  state_r;
	reg [2:0]  kind_r;
	reg [15:0] word_r;
	reg [7:0]  opnd_r;
	reg [7:0]  result_r;
	reg [1:0]  ptr_sel_r;
	reg [3:0]  ptr_hi_r;

	// resolve an 8-bit file address to a 12-bit data address
	function [11:0] file_addr;
		input [7:0] f;
		input       a;
		input [7:0] bank;
		input       ext;
		input [7:0] base;
		begin
			if (a)
				file_addr = {bank[3:0], f};
			else if (ext && f <= `ACCESS_LIMIT)
				file_addr = {4'h0, base + f};
			else if (f[7])
				file_addr = {`ACCESS_SFR_BASE, f};
			else
				file_addr = {4'h0, f};
		end
	endfunction

	function [2:0] decode;
		input [15:0] w;
		begin
			if (w[15:8] == `OP_OR_IMM)
				decode = K_OR_IMM;
			else if (w[15:8] == `OP_LOAD_BANK)
				decode = K_BANK;
			else if (w[15:10] == `OP_OR_FILE)
				decode = K_OR_F;
			else if (w[15:10] == `OP_MOVE_FILE)
				decode = K_MOV_F;
			else if (w[15:8] == `OP_LOAD_PTR && w[7:6] == 2'b00 && w[5:4] != 2'b11)
				decode = K_PTR;
			else if (w[15:12] == `OP_MM_SRC)
				decode = K_MM;
			else
				decode = K_NONE;
		end
	endfunction

	// true when a 12-bit data address names the accumulator
	function is_acc;
		input [11:0] a;
		begin
			is_acc = (a == ACC_ADDR_P);
		end
	endfunction

	// next value of one pointer; only the selected one moves
	function [11:0] ptr_next;
		input [11:0] cur;
		input [1:0]  sel;
		input [1:0]  idx;
		input        hi_wr;
		input        lo_wr;
		input [3:0]  hi;
		input [7:0]  lo;
		begin
			ptr_next = cur;
			if (hi_wr && sel == idx)
				ptr_next = {hi, cur[7:0]};
			else if (lo_wr && sel == idx)
				ptr_next = {cur[11:8], lo};
		end
	endfunction

	wire [11:0] f_addr = file_addr(word_r[7:0], word_r[8], bank_select_register,
		ext_mode, index_base);
	// the accumulator sits in the data space, so reads of it bypass memory
	wire [7:0] rd_val = is_acc(mem_addr) ? accumulator : mem_rdata;

	// decoded strobes; each state register below has its own process
	wire take        = instr_valid && instr_ready;
	wire in_q2       = (state_r == S_Q2);
	wire in_q3       = (state_r == S_Q3);
	wire in_q4       = (state_r == S_Q4);
	wire file_kind   = (kind_r == K_OR_F) || (kind_r == K_MOV_F);
	wire acc_wr_imm  = in_q4 && (kind_r == K_OR_IMM);
	wire acc_wr_file = in_q4 && file_kind && (!word_r[9] || is_acc(mem_addr));
	wire acc_wr_mm   = in_q4 && (kind_r == K_MM_DST) && is_acc(word_r[11:0]);
	wire mem_wr_file = in_q4 && file_kind && word_r[9] && !is_acc(mem_addr);
	wire mem_wr_mm   = in_q4 && (kind_r == K_MM_DST) && !is_acc(word_r[11:0]);
	wire flags_wr    = acc_wr_imm || (in_q4 && file_kind);
	wire bank_wr     = in_q4 && (kind_r == K_BANK);
	wire ptr_hi_wr   = in_q4 && (kind_r == K_PTR);
	wire ptr_lo_wr   = take && (state_r == S_PTR2) && (instr_word[15:8] == `PTR_SECOND);

	// quarter sequencer: Q1 takes a word, Q2 reads, Q3 computes, Q4 writes
	always @(posedge clk) begin
		if (sys_rst) begin
			state_r     <= S_Q1;
			instr_ready <= 1'b1;
			quarter     <= 2'd0;
		end else begin
			case (state_r)
			S_Q1: begin
				quarter <= 2'd0;
				if (take) begin
					instr_ready <= 1'b0;
					state_r     <= S_Q2;
					quarter     <= 2'd1;
				end
			end
			S_Q2: begin
				quarter <= 2'd2;
				state_r <= S_Q3;
			end
			S_Q3: begin
				quarter <= 2'd3;
				state_r <= S_Q4;
			end
			S_Q4: begin
				quarter     <= 2'd0;
				instr_ready <= 1'b1;
				if (kind_r == K_PTR)
					state_r <= S_PTR2;
				else if (kind_r == K_MM)
					state_r <= S_MM2;
				else
					state_r <= S_Q1;
			end
			S_PTR2, S_MM2: begin
				// the second word runs a full cycle of its own
				if (take) begin
					instr_ready <= 1'b0;
					state_r     <= S_Q2;
					quarter     <= 2'd1;
				end
			end
			default: begin
				state_r     <= S_Q1;
				instr_ready <= 1'b1;
				quarter     <= 2'd0;
			end
			endcase
		end
	end

	// instruction capture; a second word with the wrong prefix becomes a no-op
	always @(posedge clk) begin
		if (sys_rst) begin
			word_r <= 16'h0000;
			kind_r <= K_NONE;
		end else if (take) begin
			word_r <= instr_word;
			case (state_r)
			S_Q1:    kind_r <= decode(instr_word);
			S_MM2:   kind_r <= (instr_word[15:12] == `OP_SECOND) ? K_MM_DST : K_NONE;
			default: kind_r <= K_NONE;
			endcase
		end
	end

	// operand and result path; the move source byte is held across the second word
	always @(posedge clk) begin
		if (sys_rst) begin
			opnd_r    <= 8'h00;
			result_r  <= 8'h00;
			ptr_sel_r <= 2'h0;
			ptr_hi_r  <= 4'h0;
		end else if (in_q2) begin
			opnd_r <= word_r[7:0];
		end else if (in_q3) begin
			case (kind_r)
			K_OR_IMM: result_r <= accumulator | opnd_r;
			K_OR_F:   result_r <= accumulator | rd_val;
			K_MOV_F:  result_r <= rd_val;
			K_MM:     result_r <= rd_val;
			K_BANK:   result_r <= opnd_r & `BANK_MASK;
			K_PTR: begin
				ptr_sel_r <= word_r[5:4];
				ptr_hi_r  <= word_r[3:0];
			end
			default:  result_r <= result_r;
			endcase
		end
	end

	// read and write strobes, one cycle each; the destination word of a memory
	// move never reads, so there is no dummy read in its cycle
	always @(posedge clk) begin
		if (sys_rst) begin
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
		end else begin
			mem_rd <= in_q2 && ((file_kind && !is_acc(f_addr)) ||
				(kind_r == K_MM && !is_acc(word_r[11:0])));
			mem_wr <= mem_wr_file || mem_wr_mm;
		end
	end

	// address and write data hold between strobes
	always @(posedge clk) begin
		if (sys_rst) begin
			mem_addr  <= 12'h000;
			mem_wdata <= 8'h00;
		end else if (in_q2 && file_kind) begin
			mem_addr <= f_addr;
		end else if (in_q2 && kind_r == K_MM) begin
			mem_addr <= word_r[11:0];
		end else if (mem_wr_file) begin
			mem_wdata <= result_r;
		end else if (mem_wr_mm) begin
			mem_addr  <= word_r[11:0];
			mem_wdata <= result_r;
		end
	end

	// the extended three-cycle form of the memory move is not told apart here
	always @(posedge clk) begin
		if (sys_rst) begin
			accumulator <= `ACC_RST;
		end else if (acc_wr_imm || acc_wr_file || acc_wr_mm) begin
			accumulator <= result_r;
		end
	end

	// only the or and the single-register move touch the flags
	always @(posedge clk) begin
		if (sys_rst) begin
			flags_nz <= `FLAGS_RST;
		end else if (flags_wr) begin
			flags_nz[`FLAG_N] <= result_r[7];
			flags_nz[`FLAG_Z] <= (result_r == 8'h00);
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			bank_select_register <= `BANK_RST;
		end else if (bank_wr) begin
			bank_select_register <= result_r;
		end
	end

	// pointers: high nibble in the first cycle, low byte when the second word is taken;
	// a select of 3 never gets here, it decodes as an unknown word
	always @(posedge clk) begin
		if (sys_rst) begin
			pointer_0 <= `PTR_RST;
		end else begin
			pointer_0 <= ptr_next(pointer_0, ptr_sel_r, 2'd0, ptr_hi_wr, ptr_lo_wr,
				ptr_hi_r, instr_word[7:0]);
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			pointer_1 <= `PTR_RST;
		end else begin
			pointer_1 <= ptr_next(pointer_1, ptr_sel_r, 2'd1, ptr_hi_wr, ptr_lo_wr,
				ptr_hi_r, instr_word[7:0]);
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			pointer_2 <= `PTR_RST;
		end else begin
			pointer_2 <= ptr_next(pointer_2, ptr_sel_r, 2'd2, ptr_hi_wr, ptr_lo_wr,
				ptr_hi_r, instr_word[7:0]);
		end
	end
endmodule // or_and_move_instruction_decode
`default_nettype wire

// file: rtl/or_move_map.vh
// opcode fields, timing and reset constants for the or/and/move decoder
`ifndef OR_MOVE_MAP_VH
`define OR_MOVE_MAP_VH
`define OP_OR_IMM       8'h09
`define OP_LOAD_BANK    8'h01
`define OP_OR_FILE      6'h04
`define OP_MOVE_FILE    6'h14
`define OP_LOAD_PTR     8'hEE
`define OP_MM_SRC       4'hC
`define OP_SECOND       4'hF
`define PTR_SECOND      8'hF0
`define ACCESS_LIMIT    8'h5F
`define ACCESS_SFR_BASE 4'hF
`define ACC_ADDR        12'hFE8
`define BANK_MASK       8'h0F
`define ACC_RST         8'h00
`define BANK_RST        8'h00
`define PTR_RST         12'h000
`define FLAGS_RST       2'h0
`define FLAG_N          1
`define FLAG_Z          0
`define CLK_NS          40
`define QUARTERS        4
`endif

// file: tb/data_mem_model.sv
// behavioural data memory on the far side of the decoder
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
	// clock
	input  wire logic        clk,
	// memory port
	input  wire logic [11:0] mem_addr,
	input  wire logic        mem_wr,
	input  wire logic [7:0]  mem_wdata,
	output logic [7:0]       mem_rdata
);
	logic [7:0] mem [0:4095];
	// combinational read, as the decoder samples it in the same cycle that its read strobe is high
	assign mem_rdata = mem[mem_addr];
	always @(posedge clk) if (mem_wr) mem[mem_addr] <= mem_wdata;
endmodule // data_mem_model
`default_nettype wire

// file: tb/or_move_asserts.sv
// port checks for the or/move decoder
`timescale 1ns/1ps
`default_nettype none
`include "or_move_map.vh"
module or_move_asserts #(parameter ACC_ADDR_P = `ACC_ADDR) (
	// clock, reset, stream
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic [15:0] instr_word,
	input wire logic        instr_valid,
	input wire logic        ext_mode,
	// memory and state
	input wire logic [7:0]  mem_rdata,
	input wire logic [7:0]  index_base,
	input wire logic [11:0] mem_addr,
	input wire logic        mem_rd,
	input wire logic        mem_wr,
	input wire logic [7:0]  mem_wdata,
	input wire logic [7:0]  accumulator,
	input wire logic [7:0]  bank_select_register,
	input wire logic [11:0] pointer_0,
	input wire logic [11:0] pointer_1,
	input wire logic [11:0] pointer_2,
	input wire logic [1:0]  flags_nz,
	input wire logic        instr_ready,
	input wire logic [1:0]  quarter
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire       take = instr_valid && instr_ready;
	wire [7:0] op   = instr_word[15:8];
	logic [15:0] w_r;
	logic [7:0]  acc_r;
	// operands of the word in flight, held until the next take
	always @(posedge clk) if (take) begin
		w_r <= instr_word;
		acc_r <= accumulator;
	end
	sequence s_quads;
		quarter == 2'd1 ##1 quarter == 2'd2 ##1 quarter == 2'd3;
	endsequence
	property p_quarters; take |=> !instr_ready ##0 s_quads; endproperty
	a_quarters: assert property (p_quarters) else $error("quarter order");
	property p_or_imm;
		take && op == `OP_OR_IMM |-> ##[1:4] (instr_ready && accumulator == (acc_r | w_r[7:0]));
	endproperty
	a_or_imm: assert property (p_or_imm) else $error("or immediate result");
	property p_flags;
		take && op == `OP_OR_IMM |-> ##[1:4] (instr_ready && flags_nz == {accumulator[7], accumulator == 8'h00});
	endproperty
	a_flags: assert property (p_flags) else $error("n z flags");
	property p_keep_flags;
		take && (op == `OP_LOAD_BANK || op == `OP_LOAD_PTR) |=> $stable(flags_nz) [*4];
	endproperty
	a_keep_flags: assert property (p_keep_flags) else $error("flags touched");
	property p_bank;
		take && op == `OP_LOAD_BANK |-> ##[1:4] (instr_ready && bank_select_register == (w_r[7:0] & `BANK_MASK));
	endproperty
	a_bank: assert property (p_bank) else $error("bank load value");
	property p_bank_hi; bank_select_register[7:4] == 4'h0; endproperty
	a_bank_hi: assert property (p_bank_hi) else $error("bank upper bits");
	property p_ptr_hi;
		take && op == `OP_LOAD_PTR && instr_word[5:4] == 2'd2 |-> ##[1:4] (instr_ready && pointer_2[11:8] == w_r[3:0]);
	endproperty
	a_ptr_hi: assert property (p_ptr_hi) else $error("pointer high first");
	property p_mm_rd;
		take && instr_word[15:12] == `OP_MM_SRC && instr_word[11:0] != ACC_ADDR_P |-> ##[1:2] (mem_rd && mem_addr == w_r[11:0]);
	endproperty
	a_mm_rd: assert property (p_mm_rd) else $error("move source read");
	property p_wr; mem_wr |-> !mem_rd ##1 !mem_wr; endproperty
	a_wr: assert property (p_wr) else $error("write pulse");
endmodule // or_move_asserts
bind or_and_move_instruction_decode or_move_asserts #(.ACC_ADDR_P(ACC_ADDR_P)) i_or_move_asserts (.*);
`default_nettype wire

// file: tb/or_and_move_instruction_decode_tb.sv
// self-checking bench for the or/move decoder
`timescale 1ns/1ps
`default_nettype none
`include "or_move_map.vh"
module or_and_move_instruction_decode_tb;
	logic        clk, sys_rst, instr_valid, ext_mode, mem_rd, mem_wr, instr_ready;
	logic [15:0] instr_word;
	logic [7:0]  mem_rdata, index_base, mem_wdata, accumulator, bank_select_register;
	logic [11:0] mem_addr, pointer_0, pointer_1, pointer_2;
	logic [1:0]  flags_nz, quarter;
	int          n_mismatch, n_checks;
	or_and_move_instruction_decode i_or_and_move_instruction_decode (.*);
	data_mem_model i_data_mem_model (.*);
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	task automatic check(input string name, input [15:0] seen, input [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one word offered for a single cycle, then wait for ready again
	task automatic run(input [15:0] w);
		@(posedge clk);
		instr_word <= w;
		instr_valid <= 1'b1;
		@(posedge clk);
		instr_valid <= 1'b0;
		@(negedge clk);
		for (int i = 0; i < 20 && instr_ready !== 1'b1; i++) @(negedge clk);
		check("ready", {15'h0000, instr_ready}, 16'h0001);
		// a write issued beside ready lands on the next edge
		@(negedge clk);
	endtask
	task automatic t_or_move;
		i_data_mem_model.mem[12'h020] = 8'h9A;
		i_data_mem_model.mem[12'h021] = 8'h00;
		run(16'h5021);
		check("zero flag", {accumulator, 6'h00, flags_nz}, 16'h0001);
		run(16'h5020);
		check("move to acc", {accumulator, 6'h00, flags_nz}, 16'h9A02);
		run(16'h0935);
		check("or imm", {accumulator, 6'h00, flags_nz}, 16'hBF02);
		$display("test or_move done");
	endtask
	task automatic t_bank_or;
		run(16'h01F3);
		check("bank", {bank_select_register, 6'h00, flags_nz}, 16'h0302);
		i_data_mem_model.mem[12'h340] = 8'h40;
		run(16'h1340);
		check("or to file", {i_data_mem_model.mem[12'h340], accumulator}, 16'hFFBF);
		check("or flags", {14'h0, flags_nz}, 16'h0002);
		$display("test bank_or done");
	endtask
	task automatic t_ptr_mm;
		run(16'hEE23);
		run(16'hF0AB);
		check("pointer", {4'h0, pointer_2}, 16'h03AB);
		i_data_mem_model.mem[12'h345] = 8'h33;
		// destinations stay clear of pc low and stack top
		run(16'hC345);
		run(16'hF011);
		check("mem move", {8'h00, i_data_mem_model.mem[12'h011]}, 16'h0033);
		run(16'hC345);
		run(16'hFFE8);
		check("move to acc", {accumulator, 6'h00, flags_nz}, 16'h3302);
		$display("test ptr_mm done");
	endtask
	task automatic t_misc;
		i_data_mem_model.mem[12'hFC0] = 8'h7E;
		i_data_mem_model.mem[12'h012] = 8'h00;
		run(16'hEE05);
		run(16'hF012);
		check("pointer 0", {4'h0, pointer_0}, 16'h0512);
		run(16'h50C0);
		check("access high", {accumulator, 6'h00, flags_nz}, 16'h7E00);
		run(16'hC345);
		run(16'h0012);
		check("bad second", {8'h00, i_data_mem_model.mem[12'h012]}, 16'h0000);
		$display("test misc done");
	endtask
	task automatic t_ext;
		@(posedge clk);
		ext_mode <= 1'b1;
		index_base <= 8'h10;
		i_data_mem_model.mem[12'h015] = 8'h5A;
		run(16'h5005);
		check("indexed", {8'h00, accumulator}, 16'h005A);
		@(posedge clk);
		ext_mode <= 1'b0;
		$display("test ext done");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#(40 * 3000);
		n_mismatch++;
		final_report;
	end
	initial begin
		sys_rst = 1'b1;
		instr_valid = 1'b0;
		instr_word = 16'h0000;
		ext_mode = 1'b0;
		index_base = 8'h00;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		t_or_move;
		t_bank_or;
		t_ptr_mm;
		t_misc;
		t_ext;
		final_report;
	end
endmodule // or_and_move_instruction_decode_tb
`default_nettype wire
